// >>> hw/hpc_pkg.sv
// Constants shared by the host port control logic.
// Assumes an 8-bit host bus with a 3-bit address.
package hpc_pkg;
  localparam int HPC_DATA_W = 8;
  localparam int HPC_ADDR_W = 3;
  localparam int HPC_WORD_W = 16;

  // Host side byte addresses
  localparam logic [2:0] HPC_ADDR_CONTROL = 3'h0;
  localparam logic [2:0] HPC_ADDR_CMDVEC = 3'h1;
  localparam logic [2:0] HPC_ADDR_STATUS = 3'h2;
  localparam logic [2:0] HPC_ADDR_INTVEC = 3'h3;
  localparam logic [2:0] HPC_ADDR_DATA_A = 3'h6;
  localparam logic [2:0] HPC_ADDR_DATA_B = 3'h7;

  // host_interface_control bit positions
  localparam int HPC_CTL_RX_REQ_EN = 0;
  localparam int HPC_CTL_TX_REQ_EN = 1;
  localparam int HPC_CTL_DUAL_REQ = 2;
  localparam int HPC_CTL_FLAG_ZERO = 3;
  localparam int HPC_CTL_FLAG_ONE = 4;
  localparam int HPC_CTL_ORDER_LITTLE = 5;
  localparam int HPC_CTL_RESERVED = 6;
  localparam int HPC_CTL_INIT = 7;

  // host_side_status bit positions
  localparam int HPC_STS_RX_FULL = 0;
  localparam int HPC_STS_TX_EMPTY = 1;
  localparam int HPC_STS_TX_READY = 2;
  localparam int HPC_STS_CORE_FLAG2 = 3;
  localparam int HPC_STS_CORE_FLAG3 = 4;
  localparam int HPC_STS_REQUEST = 7;

  // Reset values
  localparam logic [7:0] HPC_CONTROL_RST = 8'h00;
  localparam logic HPC_HOST_RX_FULL_RST = 1'b0;
  localparam logic HPC_HOST_TX_EMPTY_RST = 1'b1;
  localparam logic HPC_CORE_RX_FULL_RST = 1'b0;
  localparam logic HPC_CORE_TX_EMPTY_RST = 1'b1;
  localparam logic [15:0] HPC_WORD_RST = 16'h0000;
  localparam logic [7:0] HPC_BYTE_RST = 8'h00;
  localparam logic [7:0] HPC_READ_ZERO = 8'h00;

  // Synchroniser layout: [14] cs_n, [13] rd_n, [12] wr_n,
  // [11:9] address, [8:1] data, [0] second handshake pin
  localparam int HPC_SYNC_W = 15;
  localparam logic [14:0] HPC_SYNC_IDLE = 15'h7000;

  typedef enum logic [1:0] {
    HPC_IDLE,
    HPC_READ,
    HPC_WRITE
  } hpc_access_e;
endpackage : hpc_pkg

// >>> hw/hpc_request_logic.sv
// Request pin logic of the host port.
// Assumes flags and enables come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module hpc_request_logic (
  input wire logic rxEnable,
  input wire logic txEnable,
  input wire logic dualSelect,
  input wire logic hostRxFull,
  input wire logic hostTxEmpty,
  output logic hostRequestPin,
  output logic rxRequestOut,
  output logic rxRequestOe,
  output logic anyRequest
);
  logic rxReq;
  logic txReq;

  // Each source is gated by its own enable
  assign rxReq = rxEnable & hostRxFull;
  assign txReq = txEnable & hostTxEmpty;

  // Pin one: single request or transmit request
  assign hostRequestPin = dualSelect ? txReq : (rxReq | txReq);
  // Pin two: acknowledge input unless dual mode drives it
  assign rxRequestOut = dualSelect & rxReq;
  assign rxRequestOe = dualSelect;
  // Status request bit follows whichever pins are asserted
  assign anyRequest = hostRequestPin | rxRequestOut;
endmodule : hpc_request_logic
`default_nettype wire

// >>> hw/hpc_host_port.sv
// Host port control logic: control register, handshake flags, data bytes.
// Assumes host bus pins are asynchronous; core side shares clk.
// What this block does
// - Eight-bit control register, host read/write only
// - Receive enable gates receive-full request
// - Transmit enable gates transmit-empty request
// - Single pin requests on any enabled condition
// - Dual pins each follow their own condition
// - Dual select sets second pin's direction
// - Host flag zero host-owned, shown to core
// - Host flag one host-owned, shown to core
// - Little order: high at seven, low six
// - Big order: high at six, low seven
// - Init command runs, then self-clears
// - Init presets flags per both enables
// - Reserved bit six reads as zero
// - Hardware reset clears control register
// - Receive-full sets on move, clears on last read
// - Transmit-empty sets on move, clears on last write
// - Status request bit mirrors request pins
`timescale 1ns/100ps
`default_nettype none
module hpc_host_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hostCsN,
  input wire logic hostRdN,
  input wire logic hostWrN,
  input wire logic [hpc_pkg::HPC_ADDR_W-1:0] hostAddr,
  input wire logic [hpc_pkg::HPC_DATA_W-1:0] hostDataIn,
  output logic [hpc_pkg::HPC_DATA_W-1:0] hostDataOut,
  output logic hostDataOe,
  output logic hostRequestPin,
  input wire logic rxReqAckIn,
  output logic rxReqAckOut,
  output logic rxReqAckOe,
  output logic hostAckSeen,
  input wire logic coreTxWrite,
  input wire logic [hpc_pkg::HPC_WORD_W-1:0] coreTxData,
  input wire logic coreRxRead,
  output logic [hpc_pkg::HPC_WORD_W-1:0] coreRxData,
  output logic coreRxFull,
  output logic coreTxEmpty,
  input wire logic coreFlagTwo,
  input wire logic coreFlagThree,
  output logic hostFlagZero,
  output logic hostFlagOne,
  output logic byteOrderLittle
);
  import hpc_pkg::*;

  logic [HPC_SYNC_W-1:0] pinRaw;
  logic [HPC_SYNC_W-1:0] syncA_r;
  logic [HPC_SYNC_W-1:0] syncB_r;
  logic sCsN;
  logic sRdN;
  logic sWrN;
  logic [2:0] sAddr;
  logic [7:0] sData;
  logic sAck;

  hpc_access_e state_r;
  hpc_access_e state_nxt;
  logic [2:0] latAddr_r;
  logic [7:0] latData_r;
  logic [7:0] readData_r;
  logic readOe_r;
  logic ackSeen_r;

  logic [7:0] control_r;
  logic [7:0] control_nxt;
  logic hostRxFull_r;
  logic hostRxFull_nxt;
  logic hostTxEmpty_r;
  logic hostTxEmpty_nxt;
  logic coreRxFull_r;
  logic coreRxFull_nxt;
  logic coreTxEmpty_r;
  logic coreTxEmpty_nxt;
  logic [15:0] coreTxWord_r;
  logic [15:0] coreRxWord_r;
  logic [7:0] rxHigh_r;
  logic [7:0] rxLow_r;
  logic [7:0] txHigh_r;
  logic [7:0] txLow_r;

  logic rxEn;
  logic txEn;
  logic little;
  logic initExec;
  logic initRx;
  logic initTx;
  logic [2:0] highAddr;
  logic [2:0] lowAddr;
  logic startRead;
  logic startWrite;
  logic rdEnd;
  logic wrEnd;
  logic wrControl;
  logic wrHigh;
  logic wrLow;
  logic wrLast;
  logic rdLast;
  logic moveToHost;
  logic moveToCore;
  logic txReady;
  logic anyRequest;
  logic [7:0] statusByte;
  logic [7:0] readMux;
  logic [7:0] reservedMask;

  // Host pins gathered for the synchroniser
  assign pinRaw = {hostCsN, hostRdN, hostWrN, hostAddr, hostDataIn, rxReqAckIn};

  // Two flops per pin; only the second stage is read downstream
  genvar gi;
  generate
    for (gi = 0; gi < HPC_SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          syncA_r[gi] <= HPC_SYNC_IDLE[gi];
          syncB_r[gi] <= HPC_SYNC_IDLE[gi];
        end else begin
          syncA_r[gi] <= pinRaw[gi];
          syncB_r[gi] <= syncA_r[gi];
        end
      end
    end
  endgenerate

  // Synchronised host signals
  assign sCsN = syncB_r[14];
  assign sRdN = syncB_r[13];
  assign sWrN = syncB_r[12];
  assign sAddr = syncB_r[11:9];
  assign sData = syncB_r[8:1];
  assign sAck = syncB_r[0];

  // Control fields
  assign rxEn = control_r[HPC_CTL_RX_REQ_EN];
  assign txEn = control_r[HPC_CTL_TX_REQ_EN];
  assign little = control_r[HPC_CTL_ORDER_LITTLE];
  assign initExec = control_r[HPC_CTL_INIT];
  assign initRx = initExec & rxEn;
  assign initTx = initExec & txEn;

  // Byte placement follows the order bit
  assign highAddr = little ? HPC_ADDR_DATA_B : HPC_ADDR_DATA_A;
  assign lowAddr = little ? HPC_ADDR_DATA_A : HPC_ADDR_DATA_B;

  // Access decode; writes commit when the strobe ends
  assign startRead = (state_r == HPC_IDLE) & ~sCsN & ~sRdN;
  assign startWrite = (state_r == HPC_IDLE) & ~sCsN & ~sWrN & sRdN;
  assign rdEnd = (state_r == HPC_READ) & (sRdN | sCsN);
  assign wrEnd = (state_r == HPC_WRITE) & (sWrN | sCsN);
  assign wrControl = wrEnd & (latAddr_r == HPC_ADDR_CONTROL);
  assign wrHigh = wrEnd & (latAddr_r == highAddr);
  assign wrLow = wrEnd & (latAddr_r == lowAddr);
  // Address seven is the last byte in either order
  assign wrLast = wrEnd & (latAddr_r == HPC_ADDR_DATA_B);
  assign rdLast = rdEnd & (latAddr_r == HPC_ADDR_DATA_B);

  // Word moves happen as soon as the source holds a word and the destination has room
  assign moveToHost = ~coreTxEmpty_r & ~hostRxFull_r;
  assign moveToCore = ~hostTxEmpty_r & ~coreRxFull_r;
  assign txReady = hostTxEmpty_r & ~coreRxFull_r;

  // Access state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HPC_IDLE: begin
        if (startRead) begin
          state_nxt = HPC_READ;
        end else if (startWrite) begin
          state_nxt = HPC_WRITE;
        end
      end
      HPC_READ: begin
        if (rdEnd) begin
          state_nxt = HPC_IDLE;
        end
      end
      HPC_WRITE: begin
        if (wrEnd) begin
          state_nxt = HPC_IDLE;
        end
      end
      default: begin
        state_nxt = HPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= HPC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latch address at start, data while the write strobe is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latAddr_r <= HPC_ADDR_CONTROL;
      latData_r <= HPC_BYTE_RST;
    end else if (startRead | startWrite) begin
      latAddr_r <= sAddr;
      latData_r <= sData;
    end else if ((state_r == HPC_WRITE) & ~sWrN & ~sCsN) begin
      latData_r <= sData;
    end
  end

  // Status byte seen by the host
  assign statusByte = {anyRequest, 2'b00, coreFlagThree, coreFlagTwo,
                       txReady, hostTxEmpty_r, hostRxFull_r};

  // Read selection; unused and write-only addresses read zero
  always_comb begin
    readMux = HPC_READ_ZERO;
    case (sAddr)
      HPC_ADDR_CONTROL: readMux = control_r;
      HPC_ADDR_STATUS: readMux = statusByte;
      HPC_ADDR_DATA_A: readMux = little ? rxLow_r : rxHigh_r;
      HPC_ADDR_DATA_B: readMux = little ? rxHigh_r : rxLow_r;
      default: readMux = HPC_READ_ZERO;
    endcase
  end

  // Read byte frozen for the whole strobe so it cannot tear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readData_r <= HPC_READ_ZERO;
      readOe_r <= 1'b0;
    end else begin
      if (startRead) begin
        readData_r <= readMux;
      end
      readOe_r <= (state_nxt == HPC_READ);
    end
  end

  // Reserved bit never stored, so it reads zero
  assign reservedMask = ~(8'h01 << HPC_CTL_RESERVED);

  // Control register next value
  always_comb begin
    control_nxt = control_r;
    if (wrControl) begin
      control_nxt = latData_r & reservedMask;
    end else if (initExec) begin
      // Only the command bit drops; the rest is kept
      control_nxt[HPC_CTL_INIT] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_r <= HPC_CONTROL_RST;
    end else begin
      control_r <= control_nxt;
    end
  end

  // Handshake flags; a hardware set wins over any clear
  assign hostRxFull_nxt = moveToHost | (hostRxFull_r & ~(rdLast | initRx));
  assign coreTxEmpty_nxt = moveToHost | initRx | (coreTxEmpty_r & ~coreTxWrite);
  assign hostTxEmpty_nxt = moveToCore | initTx | (hostTxEmpty_r & ~wrLast);
  assign coreRxFull_nxt = moveToCore | (coreRxFull_r & ~(coreRxRead | initTx));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hostRxFull_r <= HPC_HOST_RX_FULL_RST;
      hostTxEmpty_r <= HPC_HOST_TX_EMPTY_RST;
      coreRxFull_r <= HPC_CORE_RX_FULL_RST;
      coreTxEmpty_r <= HPC_CORE_TX_EMPTY_RST;
    end else begin
      hostRxFull_r <= hostRxFull_nxt;
      hostTxEmpty_r <= hostTxEmpty_nxt;
      coreRxFull_r <= coreRxFull_nxt;
      coreTxEmpty_r <= coreTxEmpty_nxt;
    end
  end

  // Core transmit word and receive bytes toward the host
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreTxWord_r <= HPC_WORD_RST;
      rxHigh_r <= HPC_BYTE_RST;
      rxLow_r <= HPC_BYTE_RST;
    end else begin
      if (coreTxWrite) begin
        coreTxWord_r <= coreTxData;
      end
      if (moveToHost) begin
        rxHigh_r <= coreTxWord_r[15:8];
        rxLow_r <= coreTxWord_r[7:0];
      end
    end
  end

  // Host transmit bytes and the core receive word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txHigh_r <= HPC_BYTE_RST;
      txLow_r <= HPC_BYTE_RST;
      coreRxWord_r <= HPC_WORD_RST;
    end else begin
      if (wrHigh) begin
        txHigh_r <= latData_r;
      end
      if (wrLow) begin
        txLow_r <= latData_r;
      end
      if (moveToCore) begin
        coreRxWord_r <= {txHigh_r, txLow_r};
      end
    end
  end

  // Acknowledge only means something in single-request mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ackSeen_r <= 1'b0;
    end else begin
      ackSeen_r <= sAck & ~control_r[HPC_CTL_DUAL_REQ];
    end
  end

  // Request pins from the enabled conditions
  hpc_request_logic u_request (
    .rxEnable(rxEn),
    .txEnable(txEn),
    .dualSelect(control_r[HPC_CTL_DUAL_REQ]),
    .hostRxFull(hostRxFull_r),
    .hostTxEmpty(hostTxEmpty_r),
    .hostRequestPin(hostRequestPin),
    .rxRequestOut(rxReqAckOut),
    .rxRequestOe(rxReqAckOe),
    .anyRequest(anyRequest)
  );

  // Outputs; the core sees host flags but has no write path
  assign hostDataOut = readData_r;
  assign hostDataOe = readOe_r;
  assign hostAckSeen = ackSeen_r;
  assign coreRxData = coreRxWord_r;
  assign coreRxFull = coreRxFull_r;
  assign coreTxEmpty = coreTxEmpty_r;
  assign hostFlagZero = control_r[HPC_CTL_FLAG_ZERO];
  assign hostFlagOne = control_r[HPC_CTL_FLAG_ONE];
  assign byteOrderLittle = little;
endmodule : hpc_host_port
`default_nettype wire

// >>> verif/hpc_host_port_monitor.sv
// Port checker for the host port control block.
// Assumes one clock and the synchronous active-low reset of the top.
`timescale 1ns/100ps
`default_nettype none
module hpc_host_port_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hostCsN,
  input wire logic hostRdN,
  input wire logic hostWrN,
  input wire logic hostDataOe,
  input wire logic rxReqAckOut,
  input wire logic rxReqAckOe,
  input wire logic hostAckSeen,
  input wire logic coreTxWrite,
  input wire logic coreRxRead,
  input wire logic coreRxFull,
  input wire logic coreTxEmpty,
  input wire logic hostFlagZero,
  input wire logic hostFlagOne,
  input wire logic byteOrderLittle
);
  logic [3:0] wrAge_r;
  logic [3:0] wrAge_nxt;
  // Cycles since the host write strobe was last low, saturating
  assign wrAge_nxt = !hostWrN ? 4'h0 : (wrAge_r == 4'hf) ? wrAge_r : wrAge_r + 4'h1;
  always_ff @(posedge clk) begin
    wrAge_r <= rst_n ? wrAge_nxt : 4'hf;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Reset itself is checked, so this one is never disabled
  reset_clears_a: assert property (disable iff (1'b0) !rst_n |=>
    !hostFlagZero && !hostFlagOne && !byteOrderLittle && coreTxEmpty && !coreRxFull
    && !hostDataOe && !rxReqAckOe) else $error("state not cleared by reset");
  read_drive_a: assert property ($rose(hostDataOe) |->
    !$past(hostRdN, 2) && !$past(hostCsN, 2)) else $error("data driven without read");
  drive_ends_a: assert property (hostRdN [*6] |-> !hostDataOe)
    else $error("data bus held after read");
  // Only a host write may move the host-owned flags
  flags_host_a: assert property ($changed(hostFlagZero) || $changed(hostFlagOne)
    |-> wrAge_r < 4'h6) else $error("host flag changed without host write");
  pin_dir_a: assert property (!rxReqAckOe |-> !rxReqAckOut)
    else $error("second pin driven in single mode");
  ack_quiet_a: assert property (rxReqAckOe [*3] |-> !hostAckSeen)
    else $error("acknowledge seen in dual mode");
  core_read_a: assert property (coreRxRead |=> !coreRxFull)
    else $error("core read left receive full");
  core_write_a: assert property (coreTxWrite |=> !coreTxEmpty)
    else $error("core write left transmit empty");
endmodule : hpc_host_port_monitor
bind hpc_host_port hpc_host_port_monitor u_mon (.clk, .rst_n, .hostCsN, .hostRdN,
  .hostWrN, .hostDataOe, .rxReqAckOut, .rxReqAckOe, .hostAckSeen, .coreTxWrite,
  .coreRxRead, .coreRxFull, .coreTxEmpty, .hostFlagZero, .hostFlagOne, .byteOrderLittle);
`default_nettype wire

// >>> verif/hpc_host_model.sv
// Model of the external host processor on the byte bus.
// Assumes its tasks are entered just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module hpc_host_model (
  input wire logic clk,
  output logic hostCsN,
  output logic hostRdN,
  output logic hostWrN,
  output logic [hpc_pkg::HPC_ADDR_W-1:0] hostAddr,
  output logic [hpc_pkg::HPC_DATA_W-1:0] hostDataIn,
  input wire logic [hpc_pkg::HPC_DATA_W-1:0] hostDataOut
);
  import hpc_pkg::*;
  initial begin
    hostCsN = 1'b1;
    hostRdN = 1'b1;
    hostWrN = 1'b1;
    hostAddr = 3'h0;
    hostDataIn = 8'h00;
  end
  // Strobes held 4 clocks each way, one more than the port needs
  task automatic busWrite(input logic [2:0] a, input logic [7:0] d);
    hostAddr = a;
    hostDataIn = d;
    hostCsN = 1'b0;
    hostWrN = 1'b0;
    repeat (4) @(negedge clk);
    hostCsN = 1'b1;
    hostWrN = 1'b1;
    hostDataIn = ~d; // Released bus must not keep stale data
    repeat (4) @(negedge clk);
  endtask : busWrite
  task automatic busRead(input logic [2:0] a, output logic [7:0] d);
    hostAddr = a;
    hostCsN = 1'b0;
    hostRdN = 1'b0;
    repeat (4) @(negedge clk);
    d = hostDataOut;
    hostCsN = 1'b1;
    hostRdN = 1'b1;
    repeat (4) @(negedge clk);
  endtask : busRead
endmodule : hpc_host_model
`default_nettype wire

// >>> verif/hpc_host_port_tb_top.sv
// Self-checking bench for the host port control block.
// Assumes the host model owns the bus; core side is driven here.
`timescale 1ns/100ps
`default_nettype none
module hpc_host_port_tb_top;
  import hpc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hostCsN, hostRdN, hostWrN, hostDataOe, hostRequestPin, rxReqAckOut, rxReqAckOe;
  logic [2:0] hostAddr;
  logic [7:0] hostDataIn, hostDataOut;
  logic coreTxWrite = 1'b0;
  logic coreRxRead = 1'b0;
  logic coreFlagTwo = 1'b0;
  logic hostAckDrv = 1'b0;
  logic hostAckSeen;
  logic [15:0] coreTxData = 16'h0000;
  logic [15:0] coreRxData;
  logic coreRxFull, coreTxEmpty, hostFlagZero, hostFlagOne, byteOrderLittle, rxReqAckIn;
  int err_count = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  // Second pin level: device drives it in dual mode, otherwise the bench drives it from hostAckDrv
  assign rxReqAckIn = rxReqAckOe ? rxReqAckOut : hostAckDrv;
  hpc_host_model HOST (.clk, .hostCsN, .hostRdN, .hostWrN, .hostAddr, .hostDataIn,
    .hostDataOut);
  hpc_host_port DUT (.clk, .rst_n, .hostCsN, .hostRdN, .hostWrN, .hostAddr, .hostDataIn,
    .hostDataOut, .hostDataOe, .hostRequestPin, .rxReqAckIn, .rxReqAckOut, .rxReqAckOe,
    .hostAckSeen, .coreTxWrite, .coreTxData, .coreRxRead, .coreRxData, .coreRxFull,
    .coreTxEmpty, .coreFlagTwo, .coreFlagThree(~coreFlagTwo), .hostFlagZero,
    .hostFlagOne, .byteOrderLittle);
  task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  task automatic rdChk(input string w, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    HOST.busRead(a, v);
    check(w, {8'h00, v}, {8'h00, e});
  endtask : rdChk
  // Core transmit pulse, then time for the move to land
  task automatic coreSend(input logic [15:0] d);
    coreTxData = d;
    coreTxWrite = 1'b1;
    @(negedge clk);
    coreTxWrite = 1'b0;
    repeat (3) @(negedge clk);
  endtask : coreSend
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  // Hang guard well past the longest sequence
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rdChk("ctrl", 3'h0, 8'h00);
    // Core flag three is the inverse of flag two, so it reads set here
    rdChk("status", 3'h2, 8'h16);
    coreFlagTwo = 1'b1;
    HOST.busWrite(3'h0, 8'h7e);
    rdChk("ctrl", 3'h0, 8'h3e);
    check("flags", {13'h0, hostFlagZero, hostFlagOne, byteOrderLittle}, 16'h7);
    HOST.busWrite(3'h4, 8'hff);
    rdChk("unused", 3'h4, 8'h00);
    coreSend(16'ha55a);
    // Every enable pair in both pin modes, receive full and transmit empty
    for (int m = 0; m < 8; m++) begin
      HOST.busWrite(3'h0, 8'(m));
      check("pins", {14'h0, hostRequestPin, rxReqAckOut},
        m[2] ? {14'h0, m[1], m[0]} : {14'h0, m[1] | m[0], 1'b0});
      check("pin oe", {15'h0, rxReqAckOe}, {15'h0, m[2]});
      rdChk("status", 3'h2, {m[1] | m[0], 7'h0f});
    end
    HOST.busWrite(3'h0, 8'h00);
    rdChk("big hi", 3'h6, 8'ha5);
    rdChk("big lo", 3'h7, 8'h5a);
    rdChk("status", 3'h2, 8'h0e);
    HOST.busWrite(3'h0, 8'h20);
    coreSend(16'h1234);
    rdChk("lit lo", 3'h6, 8'h34);
    rdChk("lit hi", 3'h7, 8'h12);
    HOST.busWrite(3'h6, 8'hcd);
    HOST.busWrite(3'h7, 8'hab);
    rdChk("status", 3'h2, 8'h0a);
    check("core rx", coreRxData, 16'habcd);
    // Block both directions so the presets have something to undo
    HOST.busWrite(3'h6, 8'h11);
    HOST.busWrite(3'h7, 8'h22);
    coreSend(16'h5555);
    coreSend(16'h6666);
    HOST.busWrite(3'h0, 8'h83);
    rdChk("init ctrl", 3'h0, 8'h03);
    rdChk("init sts", 3'h2, 8'h8e);
    check("init core", {14'h0, coreRxFull, coreTxEmpty}, 16'h1);
    HOST.busWrite(3'h0, 8'h80);
    rdChk("init none", 3'h0, 8'h00);
    // Big order host word, then a core read while the word is still held
    HOST.busWrite(3'h6, 8'h33);
    HOST.busWrite(3'h7, 8'h44);
    check("core rx2", coreRxData, 16'h3344);
    check("core full", {15'h0, coreRxFull}, 16'h1);
    coreRxRead = 1'b1;
    @(negedge clk);
    coreRxRead = 1'b0;
    repeat (2) @(negedge clk);
    check("core read", {15'h0, coreRxFull}, 16'h0);
    // Block both sides again, then undo one direction at a time
    HOST.busWrite(3'h6, 8'h77);
    HOST.busWrite(3'h7, 8'h88);
    HOST.busWrite(3'h6, 8'h99);
    HOST.busWrite(3'h7, 8'haa);
    coreSend(16'h7777);
    coreSend(16'h8888);
    HOST.busWrite(3'h0, 8'h81);
    rdChk("rx init sts", 3'h2, 8'h08);
    check("rx init core", {14'h0, coreRxFull, coreTxEmpty}, 16'h3);
    check("core hold", coreRxData, 16'h7788);
    HOST.busWrite(3'h0, 8'h82);
    rdChk("tx init ctrl", 3'h0, 8'h02);
    rdChk("tx init sts", 3'h2, 8'h8e);
    check("tx init core", {14'h0, coreRxFull, coreTxEmpty}, 16'h1);
    // Acknowledge pin is an input only in single-request mode
    hostAckDrv = 1'b1;
    repeat (4) @(negedge clk);
    check("ack seen", {15'h0, hostAckSeen}, 16'h1);
    hostAckDrv = 1'b0;
    repeat (4) @(negedge clk);
    check("ack gone", {15'h0, hostAckSeen}, 16'h0);
    complete_run();
  end
endmodule : hpc_host_port_tb_top
`default_nettype wire
